// ===== include/dsr_defs.vh
// Constants for the debug signal router: register map, command fields,
// group and pin codes, reset values and sizes.
// Assumes inclusion by the router module and the testbench top.
`ifndef DSR_DEFS_VH
`define DSR_DEFS_VH

// Register byte offsets on the AHB-Lite bus.
`define DSR_REG_ENABLE      8'h00
`define DSR_REG_DIG_CMD     8'h04
`define DSR_REG_ANA_CMD     8'h08
`define DSR_REG_STATUS      8'h0C
`define DSR_REG_PIN_CFG0    8'h10
`define DSR_REG_PIN_CFG1    8'h14
`define DSR_REG_PIN_CFG2    8'h18
`define DSR_REG_PIN_CFG3    8'h1C

// Nonvolatile byte address that holds the debug bus enable setting.
`define DSR_NV_ENABLE_ADDR  8'h17

// Command fields.
`define DSR_P1_LSB          0
`define DSR_P1_MSB          7
`define DSR_P2_LSB          8
`define DSR_P2_MSB          15
`define DSR_SIG_LSB         0
`define DSR_SIG_MSB         3
`define DSR_PIN_LSB         4
`define DSR_PIN_MSB         7

// Limits on simultaneous probes, and the probe input bus width.
`define DSR_NUM_DIG         4
`define DSR_NUM_ANA         2
`define DSR_PROBE_BITS      46

// Probe modes.
`define DSR_MODE_OFF        2'h0
`define DSR_MODE_ANALOG     2'h1
`define DSR_MODE_DIGITAL    2'h2

// Signal group codes.
`define DSR_GRP_CLOCK       8'h01
`define DSR_GRP_TX_ENC      8'h1B
`define DSR_GRP_TIMER       8'h1D
`define DSR_GRP_CARD        8'h30
`define DSR_GRP_TRX         8'h58
`define DSR_GRP_RX_DATA     8'h70
`define DSR_GRP_RX_ERR      8'h73

// Signal code that selects the 13.56 MHz carrier in each of the seven decoded groups.
`define DSR_SIG_CARRIER     4'h8

// Output pin codes.
`define DSR_PIN_IRQ         4'h0
`define DSR_PIN_GENERAL_OUTPUT_ONE        4'h1
`define DSR_PIN_SPARE_B     4'h2
`define DSR_PIN_SPARE_A     4'h3

// Analog source codes accepted by the converters.
`define DSR_ANA_SRC_MAX     8'h03

// Reset values.
`define DSR_RST_ENABLE      1'b0
`define DSR_RST_CFG         12'h000
`define DSR_RST_DAC         8'h00
`define DSR_RST_WORD        32'h00000000

`endif

// ===== core/dsr_sync.v
// Two-stage synchroniser for a vector of asynchronous probe inputs.
// Assumes the inputs come from other clock domains or from pins.
`timescale 1ns/1ps
`default_nettype none

module dsr_sync
#(
	parameter WIDTH = 8
)
(
	input  wire             hclk,
	input  wire             hresetn,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	// ----------------------------------------------------------------
	// Per-bit flip-flop pair.
	// ----------------------------------------------------------------

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			reg stage1;
			reg stage2;
			always @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
				end
				else
				begin
					stage1 <= async_in[i];
					stage2 <= stage1;
				end
			end
			assign sync_out[i] = stage2;
		end
	endgenerate

endmodule

`default_nettype wire

// ===== core/dsr_router.v
// Debug signal router core with an AHB-Lite register slave.
// Assumes probe inputs arrive asynchronously and signal processor
// samples arrive on hclk.
//
// Functional notes
// [RULE_01] Two analog or four digital probes.
// [RULE_02] Routing works only with enable setting.
// [RULE_03] Separate digital and analog configuration commands.
// [RULE_04] First digital parameter byte is group.
// [RULE_05] Low nibble picks signal in group.
// [RULE_06] High nibble picks output pin.
// [RULE_07] Signal code 8 gives carrier clock.
// [RULE_08] Decode the seven group codes.
// [RULE_09] Clock group signal mapping.
// [RULE_10] Transmit encoder group signal mapping.
// [RULE_11] Timer group running and expiry flags.
// [RULE_12] Card-mode group signal mapping.
// [RULE_13] Transceive group signal mapping.
// [RULE_14] Receiver data group signal mapping.
// [RULE_15] Receiver error group signal mapping.
// [RULE_16] Two converters show processor data live.
// [RULE_17] Reserved selections leave pins normal.
`timescale 1ns/1ps
`default_nettype none
`include "dsr_defs.vh"

module dsr_router
(
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        carrier_clk,
	input  wire [7:0]  clock_grp,
	input  wire [1:0]  tx_enc_grp,
	input  wire [5:0]  timer_grp,
	input  wire [7:0]  card_grp,
	input  wire [7:0]  trx_grp,
	input  wire [7:0]  rx_data_grp,
	input  wire [4:0]  rx_err_grp,
	input  wire [31:0] signal_processor_data,
	output reg  [3:0]  probe_active,
	output reg  [3:0]  probe_value,
	output reg  [7:0]  dac_one,
	output reg  [7:0]  dac_two
);

	// ----------------------------------------------------------------
	// Probe input synchronisation.
	// ----------------------------------------------------------------

	wire [`DSR_PROBE_BITS-1:0] raw_bus;
	wire [`DSR_PROBE_BITS-1:0] syn_bus;

	assign raw_bus = {carrier_clk, clock_grp, tx_enc_grp, timer_grp,
		card_grp, trx_grp, rx_data_grp, rx_err_grp};

	dsr_sync #(.WIDTH(`DSR_PROBE_BITS)) u_sync
	(
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (raw_bus),
		.sync_out (syn_bus)
	);

	wire       s_carrier;
	wire [7:0] s_clock;
	wire [1:0] s_tx;
	wire [5:0] s_timer;
	wire [7:0] s_card;
	wire [7:0] s_trx;
	wire [7:0] s_rxd;
	wire [4:0] s_rxe;

	assign s_carrier = syn_bus[45];
	assign s_clock   = syn_bus[44:37];
	assign s_tx      = syn_bus[36:35];
	assign s_timer   = syn_bus[34:29];
	assign s_card    = syn_bus[28:21];
	assign s_trx     = syn_bus[20:13];
	assign s_rxd     = syn_bus[12:5];
	assign s_rxe     = syn_bus[4:0];

	// ----------------------------------------------------------------
	// Register state.
	// ----------------------------------------------------------------

	reg        nv_enable;
	reg [1:0]  mode;
	reg [11:0] pin_cfg [0:`DSR_NUM_DIG-1];
	reg [3:0]  pin_valid;
	reg [7:0]  ana_src_one;
	reg [7:0]  ana_src_two;
	reg [7:0]  addr_q;
	reg        wr_q;
	reg        rd_stage;

	wire addr_take;
	assign addr_take = hsel & htrans[1] & hready;

	wire [7:0] p1;
	wire [7:0] p2;
	wire [3:0] cmd_pin;
	wire [3:0] cmd_sig;

	assign p1      = hwdata[`DSR_P1_MSB:`DSR_P1_LSB];
	assign p2      = hwdata[`DSR_P2_MSB:`DSR_P2_LSB];
	assign cmd_pin = p2[`DSR_PIN_MSB:`DSR_PIN_LSB];
	assign cmd_sig = p2[`DSR_SIG_MSB:`DSR_SIG_LSB];

	wire dig_write;
	wire ana_write;
	wire en_write;

	assign en_write  = wr_q & (addr_q == `DSR_REG_ENABLE);
	assign dig_write = wr_q & (addr_q == `DSR_REG_DIG_CMD) & nv_enable; // see [RULE_02]
	assign ana_write = wr_q & (addr_q == `DSR_REG_ANA_CMD) & nv_enable; // see [RULE_02]

	wire pin_legal;
	assign pin_legal = (cmd_pin <= `DSR_PIN_SPARE_A); // see [RULE_06]

	// ----------------------------------------------------------------
	// AHB-Lite slave: address capture, writes and read wait state.
	// ----------------------------------------------------------------

	integer k;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_q    <= 8'h00;
			wr_q      <= 1'b0;
			rd_stage  <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hresp <= 1'b0;
			wr_q  <= addr_take & hwrite;
			if (addr_take)
			begin
				addr_q <= haddr[7:0];
			end
			if (addr_take & ~hwrite)
			begin
				rd_stage  <= 1'b1;
				hreadyout <= 1'b0;
			end
			else if (rd_stage)
			begin
				rd_stage  <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			nv_enable   <= `DSR_RST_ENABLE;
			mode        <= `DSR_MODE_OFF;
			pin_valid   <= 4'h0;
			ana_src_one <= `DSR_RST_DAC;
			ana_src_two <= `DSR_RST_DAC;
			for (k = 0; k < `DSR_NUM_DIG; k = k + 1)
			begin
				pin_cfg[k] <= `DSR_RST_CFG;
			end
		end
		else
		begin
			if (en_write)
			begin
				nv_enable <= hwdata[0];
			end
			if (dig_write)
			begin
				mode <= `DSR_MODE_DIGITAL; // see [RULE_01] [RULE_03]
				if (mode != `DSR_MODE_DIGITAL)
				begin
					pin_valid <= 4'h0;
				end
				if (pin_legal)
				begin
					pin_cfg[cmd_pin[1:0]]   <= {p1, cmd_sig}; // see [RULE_04] [RULE_05]
					pin_valid[cmd_pin[1:0]] <= 1'b1; // see [RULE_06]
				end
			end
			else if (ana_write)
			begin
				mode        <= `DSR_MODE_ANALOG; // see [RULE_01] [RULE_03]
				pin_valid   <= 4'h0;
				ana_src_one <= p1;
				ana_src_two <= p2;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read multiplexer, loaded during the read wait state.
	// ----------------------------------------------------------------

	reg [31:0] rd_mux;

	always @*
	begin
		rd_mux = `DSR_RST_WORD;
		case (addr_q)
			`DSR_REG_ENABLE:   rd_mux = {31'h00000000, nv_enable};
			`DSR_REG_ANA_CMD:  rd_mux = {16'h0000, ana_src_two, ana_src_one};
			`DSR_REG_STATUS:   rd_mux = {16'h0000, probe_active,
				pin_valid, 5'h00, nv_enable, mode};
			`DSR_REG_PIN_CFG0: rd_mux = {19'h00000, pin_valid[0], pin_cfg[0]};
			`DSR_REG_PIN_CFG1: rd_mux = {19'h00000, pin_valid[1], pin_cfg[1]};
			`DSR_REG_PIN_CFG2: rd_mux = {19'h00000, pin_valid[2], pin_cfg[2]};
			`DSR_REG_PIN_CFG3: rd_mux = {19'h00000, pin_valid[3], pin_cfg[3]};
			default:           rd_mux = `DSR_RST_WORD;
		endcase
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= `DSR_RST_WORD;
		end
		else if (rd_stage)
		begin
			hrdata <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Signal selection per output pin.
	// ----------------------------------------------------------------

	function [1:0] pick;
		input [7:0] grp;
		input [3:0] sig;
		input       car;
		input [7:0] clk_v;
		input [1:0] tx_v;
		input [5:0] tim_v;
		input [7:0] card_v;
		input [7:0] trx_v;
		input [7:0] rxd_v;
		input [4:0] rxe_v;
		reg         legal_grp;
		begin
			legal_grp = 1'b1;
			pick = 2'b00;
			case (grp) // see [RULE_08]
				`DSR_GRP_CLOCK:   pick = {1'b1, clk_v[sig[2:0]]}; // see [RULE_09]
				`DSR_GRP_TX_ENC:
				begin
					if (sig < 4'h2)
						pick = {1'b1, tx_v[sig[0]]}; // see [RULE_10]
				end
				`DSR_GRP_TIMER:
				begin
					if (sig >= 4'h2 && sig <= 4'h7)
						pick = {1'b1, tim_v[sig[2:0] - 3'h2]}; // see [RULE_11]
				end
				`DSR_GRP_CARD:    pick = {1'b1, card_v[sig[2:0]]}; // see [RULE_12]
				`DSR_GRP_TRX:     pick = {1'b1, trx_v[sig[2:0]]}; // see [RULE_13]
				`DSR_GRP_RX_DATA: pick = {1'b1, rxd_v[sig[2:0]]}; // see [RULE_14]
				`DSR_GRP_RX_ERR:
				begin
					if (sig <= 4'h2)
						pick = {1'b1, rxe_v[sig[1:0]]}; // see [RULE_15]
					else if (sig >= 4'h6 && sig <= 4'h7)
						pick = {1'b1, rxe_v[sig[2:0] - 3'h3]}; // see [RULE_15]
				end
				default:          legal_grp = 1'b0;
			endcase
			if (sig > `DSR_SIG_CARRIER)
				pick = 2'b00; // see [RULE_17]
			else if (sig == `DSR_SIG_CARRIER && legal_grp)
				pick = {1'b1, car}; // see [RULE_07]
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < `DSR_NUM_DIG; g = g + 1)
		begin : g_pin
			wire [1:0] sel;
			wire       drive_on;
			assign sel = pick(pin_cfg[g][11:4], pin_cfg[g][3:0], s_carrier,
				s_clock, s_tx, s_timer, s_card, s_trx, s_rxd, s_rxe);
			assign drive_on = nv_enable & pin_valid[g] & sel[1] &
				(mode == `DSR_MODE_DIGITAL); // see [RULE_02] [RULE_17]
			always @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					probe_active[g] <= 1'b0;
					probe_value[g]  <= 1'b0;
				end
				else
				begin
					probe_active[g] <= drive_on;
					probe_value[g]  <= drive_on & sel[0];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Analog probe converters fed from the signal processor.
	// ----------------------------------------------------------------

	function [7:0] ana_pick;
		input [7:0]  src;
		input [31:0] data;
		begin
			ana_pick = `DSR_RST_DAC;
			case (src)
				8'h00:   ana_pick = data[7:0];
				8'h01:   ana_pick = data[15:8];
				8'h02:   ana_pick = data[23:16];
				8'h03:   ana_pick = data[31:24];
				default: ana_pick = `DSR_RST_DAC;
			endcase
		end
	endfunction

	wire ana_on;
	assign ana_on = nv_enable & (mode == `DSR_MODE_ANALOG);

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dac_one <= `DSR_RST_DAC;
			dac_two <= `DSR_RST_DAC;
		end
		else if (ana_on)
		begin
			dac_one <= ana_pick(ana_src_one, signal_processor_data); // see [RULE_16]
			dac_two <= ana_pick(ana_src_two, signal_processor_data); // see [RULE_16]
		end
		else
		begin
			dac_one <= `DSR_RST_DAC;
			dac_two <= `DSR_RST_DAC;
		end
	end

endmodule

`default_nettype wire

// ===== tb/dsr_monitor.sv
// Checker for the debug signal router bus slave and probe outputs.
// Assumes it is bound to the router top module.
`timescale 1ns/1ps
`default_nettype none

module dsr_monitor
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [3:0]  probe_active,
	input wire logic [3:0]  probe_value,
	input wire logic [7:0]  dac_one,
	input wire logic [7:0]  dac_two
);
	// ----------------------------------------
	// Helper logic.
	// ----------------------------------------
	wire  take = hsel & htrans[1] & hready;
	logic en_ph;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			en_ph <= 1'b0;
		else
			en_ph <= take & hwrite & (haddr[7:0] == 8'h00);
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_ready_cause: assert property (!hreadyout |-> $past(take && !hwrite))
		else $error("stall without read");
	a_rdata_hold: assert property ($changed(hrdata) |-> $past(!hreadyout))
		else $error("read data moved");
	a_excl_modes: assert property (|probe_active |-> dac_one == 8'h00 && dac_two == 8'h00)
		else $error("digital and analog probes together");
	a_value_gated: assert property ((probe_value & ~probe_active) == 4'h0)
		else $error("probe level on idle pin");
	a_enable_drop: assert property (en_ph && !hwdata[0] |-> ##[1:2] probe_active == 4'h0)
		else $error("probes kept after disable");
endmodule

`default_nettype wire

// ===== tb/dsr_host_model.sv
// Host controller model issuing single word transfers on AHB-Lite.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none

module dsr_host_model
(
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [31:0] hwdata
);
	initial
	begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
	end

	// Holds each phase until hready is sampled high at a rising edge.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		hsize  <= 3'h2;
		htrans <= 2'h2;
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for the debug signal router: reset and refusal cases, a table
// of groups and codes, then analog, enable and reset cases.
// Assumes the router core and its defines header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "dsr_defs.vh"

module tb_top;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel, hwrite, hready, hresp;
	logic        carrier_clk;
	logic [31:0] haddr, hwdata, hrdata, signal_processor_data, q;
	logic [1:0]  htrans, tx_enc_grp;
	logic [2:0]  hsize;
	logic [7:0]  clock_grp, card_grp, trx_grp, rx_data_grp, dac_one, dac_two;
	logic [5:0]  timer_grp;
	logic [4:0]  rx_err_grp;
	logic [3:0]  probe_active, probe_value;
	logic [1:0]  p;
	logic [7:0]  gc;
	int          errors, checks, r, s;
	logic [23:0] rows [8] = '{24'h0101FF, 24'h1B0103, 24'h1D01FC,
		24'h3001FF, 24'h5801FF, 24'h7001FF, 24'h7301C7, 24'h100000};

	always #2 hclk = ~hclk;

	dsr_router dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
		.carrier_clk, .clock_grp, .tx_enc_grp, .timer_grp, .card_grp,
		.trx_grp, .rx_data_grp, .rx_err_grp, .signal_processor_data,
		.probe_active, .probe_value, .dac_one, .dac_two);
	dsr_host_model host_u (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata);

	// ----------------------------------------
	// Tasks.
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
		end
	endtask

	task close_out;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		host_u.xfer(1'b0, a, 32'h0, q);
		check(q, e);
	endtask

	task automatic wait3;
		repeat (3) @(posedge hclk);
		#1;
	endtask

	// Drives the source bit indexed by group g and code c to b and every other source bit to its inverse.
	task automatic setin(input logic [7:0] g, input int c, input logic b);
		logic [45:0] v;
		int          i;
		@(posedge hclk);
		v = {46{~b}};
		case (g)
			8'h01: i = c;
			8'h1B, 8'h1D: i = 8 + c;
			8'h30: i = 16 + c;
			8'h58: i = 24 + c;
			8'h70: i = 32 + c;
			8'h73: i = (c < 3) ? 40 + c : 37 + c;
			default: i = 46;
		endcase
		if (c == 8)
			i = 45;
		if (i < 46)
			v[i] = b;
		{carrier_clk, rx_err_grp, rx_data_grp, trx_grp, card_grp, timer_grp,
			tx_enc_grp, clock_grp} <= v;
	endtask

	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial
	begin
		signal_processor_data = 32'hA1B2C3D4;
		{carrier_clk, rx_err_grp, rx_data_grp, trx_grp, card_grp, timer_grp,
			tx_enc_grp, clock_grp} = 46'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		check({probe_value, probe_active}, 32'h0);
		rd(`DSR_REG_STATUS, 32'h0);
		wr(`DSR_REG_DIG_CMD, 32'h0801);
		wait3;
		check(probe_active, 4'h0);
		wr(`DSR_REG_ENABLE, 32'h1);
		rd(`DSR_REG_ENABLE, 32'h1);
		for (r = 0; r < 8; r++)
			for (s = 0; s < 16; s++)
			begin
				p = s[1:0];
				gc = rows[r][23:16];
				setin(gc, s, 1'b1);
				wr(`DSR_REG_DIG_CMD, {18'h0, p, s[3:0], gc});
				wait3;
				check(probe_active[p], rows[r][s]);
				check(probe_value[p], rows[r][s]);
				setin(gc, s, 1'b0);
				wait3;
				check(probe_value[p], 32'h0);
			end
		for (s = 4; s < 16; s++)
			wr(`DSR_REG_DIG_CMD, {16'h0, s[3:0], 12'h001});
		wait3;
		check(probe_active, 4'h0);
		wr(`DSR_REG_DIG_CMD, 32'h3501);
		rd(`DSR_REG_PIN_CFG3, 32'h1015);
		wr(`DSR_REG_ANA_CMD, 32'h0301);
		wait3;
		check({probe_active, dac_two, dac_one}, 20'h0A1C3);
		@(posedge hclk);
		signal_processor_data <= 32'h5A6B7C8D;
		wait3;
		check(dac_one, 8'h7C);
		rd(`DSR_REG_STATUS, 32'h5);
		wr(`DSR_REG_ANA_CMD, 32'h0004);
		wait3;
		check({dac_two, dac_one}, 16'h8D00);
		setin(8'h01, 8, 1'b1);
		wr(`DSR_REG_DIG_CMD, 32'h0801);
		wait3;
		check({probe_value, probe_active, dac_one}, 16'h1100);
		wr(`DSR_REG_ENABLE, 32'h0);
		wait3;
		check({probe_value, probe_active}, 32'h0);
		wr(`DSR_REG_ENABLE, 32'h1);
		wait3;
		check({probe_value, probe_active}, 32'h11);
		rd(`DSR_REG_ENABLE, 32'h1);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		check({probe_value, probe_active, dac_two, dac_one}, 32'h0);
		check({hresp, hready}, 32'h1);
		check(hrdata, 32'h0);
		hresetn <= 1'b1;
		rd(`DSR_REG_ENABLE, 32'h0);
		rd(`DSR_REG_PIN_CFG0, 32'h0);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		close_out;
	end

	initial
	begin
		#100000;
		errors++;
		close_out;
	end
endmodule

bind dsr_router dsr_monitor mon_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .probe_active,
	.probe_value, .dac_one, .dac_two);

`default_nettype wire
